// ### include/aocs_pkg.sv
// Purpose: shared constants and carriers for the analog output calibration strobes
// Assumes: 16-bit word-only host I/O window, offsets are byte addresses
// Notes:   offsets step by two, one word each
//
// How it works
// - write at 1EH latches data bits 7..0 as trim value, upper byte ignored
// - read at 1EH returns 8-bit calibration result, upper byte zero
// - first write at 18H after a trim write triggers parameter save to EEPROM, unless 24H was written in between
// - any write at 20H updates all outputs with pending data together
// - in sync mode channel writes stay pending, otherwise update immediately
// - any write at 22H resets all analog outputs at once
// - any write at 24H resets the calibration controller state
// - any write at 26H applies the pending range setting to its channel
// - register 28H bits 1..0 choose reference -10V, 0V, unused, +10V
`default_nettype none

package aocs_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W       = 6;
  localparam int unsigned DATA_W       = 16;
  localparam int unsigned CHAN_N       = 8;
  localparam int unsigned CHAN_W       = 3;
  localparam int unsigned TRIM_W       = 8;
  localparam int unsigned REF_W        = 2;
  localparam int unsigned CHAN_IDX_LSB = 1;

  // ----------------------------------------------------------------
  // offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CHAN_LAST = 6'h0f;
  localparam logic [ADDR_W-1:0] OFS_SAVE      = 6'h18;
  localparam logic [ADDR_W-1:0] OFS_TRIM      = 6'h1e;
  localparam logic [ADDR_W-1:0] OFS_SYNC      = 6'h20;
  localparam logic [ADDR_W-1:0] OFS_RST_ALL   = 6'h22;
  localparam logic [ADDR_W-1:0] OFS_CAL_RST   = 6'h24;
  localparam logic [ADDR_W-1:0] OFS_TYPE_CHG  = 6'h26;
  localparam logic [ADDR_W-1:0] OFS_REF_SEL   = 6'h28;

  // ----------------------------------------------------------------
  // codes and reset values
  // ----------------------------------------------------------------
  localparam logic [REF_W-1:0]  REF_NEG10   = 2'h0;
  localparam logic [REF_W-1:0]  REF_ZERO    = 2'h1;
  localparam logic [REF_W-1:0]  REF_UNUSED  = 2'h2;
  localparam logic [REF_W-1:0]  REF_POS10   = 2'h3;
  localparam logic [REF_W-1:0]  REF_RESET   = 2'h1;
  localparam logic [TRIM_W-1:0] TRIM_RESET  = 8'h00;
  localparam logic [DATA_W-1:0] RDATA_RESET = 16'h0000;
  localparam logic [DATA_W-TRIM_W-1:0] UPPER_ZERO = 8'h00;

  // ----------------------------------------------------------------
  // decoded write strobes, one pulse per host write
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              chan;
    logic              save;
    logic              trim;
    logic              sync;
    logic              rst_all;
    logic              cal_rst;
    logic              type_chg;
    logic              ref_sel;
    logic [CHAN_W-1:0] chan_idx;
    logic [DATA_W-1:0] data;
  } aocs_wstb_s;

endpackage : aocs_pkg

`default_nettype wire

// ### core/aocs_wr_decode.sv
// Purpose: turn host write cycles into one-cycle decoded strobes
// Assumes: io_wr high for one or more cycles per write, address stable
// Notes:   rising edge detect so a stretched write still pulses once
`default_nettype none

module aocs_wr_decode (
  input  wire logic                        clk_sys,
  input  wire logic                        rst_b,
  input  wire logic                        io_wr,
  input  wire logic [aocs_pkg::ADDR_W-1:0] io_addr,
  input  wire logic [aocs_pkg::DATA_W-1:0] io_wdata,
  output var aocs_pkg::aocs_wstb_s         wstb
);

  typedef struct packed {
    logic                 wr_seen;
    aocs_pkg::aocs_wstb_s stb;
  } aocs_dec_s;

  aocs_dec_s st_reg;
  aocs_dec_s st_next;
  logic      wr_rise;

  always_comb begin
    wr_rise               = io_wr & ~st_reg.wr_seen;
    st_next               = '0;
    st_next.wr_seen       = io_wr;
    st_next.stb.data      = io_wdata;
    st_next.stb.chan_idx  = io_addr[aocs_pkg::CHAN_IDX_LSB +: aocs_pkg::CHAN_W];
    st_next.stb.chan      = wr_rise && (io_addr <= aocs_pkg::OFS_CHAN_LAST);
    st_next.stb.save      = wr_rise && (io_addr == aocs_pkg::OFS_SAVE);
    st_next.stb.trim      = wr_rise && (io_addr == aocs_pkg::OFS_TRIM);
    st_next.stb.sync      = wr_rise && (io_addr == aocs_pkg::OFS_SYNC);
    st_next.stb.rst_all   = wr_rise && (io_addr == aocs_pkg::OFS_RST_ALL);
    st_next.stb.cal_rst   = wr_rise && (io_addr == aocs_pkg::OFS_CAL_RST);
    st_next.stb.type_chg  = wr_rise && (io_addr == aocs_pkg::OFS_TYPE_CHG);
    st_next.stb.ref_sel   = wr_rise && (io_addr == aocs_pkg::OFS_REF_SEL);
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign wstb = st_reg.stb;

  one_pulse_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    (wstb.sync | wstb.save | wstb.rst_all) |=> !(wstb.sync | wstb.save | wstb.rst_all)
  ) else $error("strobe pulse longer than one cycle");

endmodule : aocs_wr_decode

`default_nettype wire

// ### core/aocs_regs.sv
// Purpose: calibration trim, reference select and write strobes of the output card
// Assumes: host makes word-wide accesses only, io_rd is a one-cycle strobe
// Notes:   all outputs registered; strobes appear two cycles after io_wr rises
`default_nettype none

module aocs_regs (
  input  wire logic                        clk_sys,
  input  wire logic                        rst_b,
  input  wire logic                        io_wr,
  input  wire logic                        io_rd,
  input  wire logic [aocs_pkg::ADDR_W-1:0] io_addr,
  input  wire logic [aocs_pkg::DATA_W-1:0] io_wdata,
  output logic      [aocs_pkg::DATA_W-1:0] io_rdata,
  output logic                             io_rvalid,
  input  wire logic                        sync_mode_en,
  input  wire logic [aocs_pkg::TRIM_W-1:0] cal_result,
  output logic      [aocs_pkg::TRIM_W-1:0] cal_trim_value,
  output logic                             cal_trim_load,
  output logic                             cal_param_save,
  output logic                             cal_ctrl_reset,
  output logic      [aocs_pkg::CHAN_N-1:0] chan_update,
  output logic      [aocs_pkg::CHAN_N-1:0] chan_pending,
  output logic                             all_outputs_reset,
  output logic                             output_type_apply,
  output logic                             reference_select_high_bit,
  output logic                             reference_select_low_bit,
  output logic                             reference_enable
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [aocs_pkg::TRIM_W-1:0] trim;
    logic                        trim_stb;
    logic                        trim_armed;
    logic                        save_stb;
    logic                        cal_rst_stb;
    logic [aocs_pkg::CHAN_N-1:0] pend;
    logic [aocs_pkg::CHAN_N-1:0] update;
    logic                        rst_all_stb;
    logic                        type_chg_stb;
    logic [aocs_pkg::REF_W-1:0]  ref_code;
    logic                        ref_en;
    logic [aocs_pkg::DATA_W-1:0] rdata;
    logic                        rvalid;
  } aocs_regs_s;

  localparam aocs_regs_s ST_RESET = '{
    trim:         aocs_pkg::TRIM_RESET,
    trim_stb:     1'b0,
    trim_armed:   1'b0,
    save_stb:     1'b0,
    cal_rst_stb:  1'b0,
    pend:         '0,
    update:       '0,
    rst_all_stb:  1'b0,
    type_chg_stb: 1'b0,
    ref_code:     aocs_pkg::REF_RESET,
    ref_en:       1'b1,
    rdata:        aocs_pkg::RDATA_RESET,
    rvalid:       1'b0
  };

  aocs_regs_s           st_reg;
  aocs_regs_s           st_next;
  aocs_pkg::aocs_wstb_s wstb;

  // ----------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------
  aocs_wr_decode u_wr_decode (
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .io_wr    (io_wr),
    .io_addr  (io_addr),
    .io_wdata (io_wdata),
    .wstb     (wstb)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_next              = st_reg;
    st_next.trim_stb     = 1'b0;
    st_next.save_stb     = 1'b0;
    st_next.cal_rst_stb  = 1'b0;
    st_next.update       = '0;
    st_next.rst_all_stb  = 1'b0;
    st_next.type_chg_stb = 1'b0;
    st_next.rvalid       = 1'b0;

    // trim value, upper byte dropped
    if (wstb.trim) begin
      st_next.trim       = wstb.data[aocs_pkg::TRIM_W-1:0];
      st_next.trim_stb   = 1'b1;
      st_next.trim_armed = 1'b1;
    end

    // save only once a trim has been loaded; a save with nothing new is dropped
    if (wstb.save && st_reg.trim_armed) begin
      st_next.save_stb   = 1'b1;
      st_next.trim_armed = 1'b0;
    end

    // controller reset forgets an unsaved trim
    if (wstb.cal_rst) begin
      st_next.cal_rst_stb = 1'b1;
      st_next.trim_armed  = 1'b0;
    end

    // channel data writes: immediate or held for the sync strobe
    if (wstb.chan) begin
      if (sync_mode_en) begin
        st_next.pend[wstb.chan_idx] = 1'b1;
      end else begin
        st_next.update[wstb.chan_idx] = 1'b1;
      end
    end

    if (wstb.sync) begin
      st_next.update = st_reg.pend;
      st_next.pend   = '0;
    end

    // reset of all outputs also drops anything still pending
    if (wstb.rst_all) begin
      st_next.rst_all_stb = 1'b1;
      st_next.pend        = '0;
    end

    if (wstb.type_chg) begin
      st_next.type_chg_stb = 1'b1;
    end

    if (wstb.ref_sel) begin
      st_next.ref_code = wstb.data[aocs_pkg::REF_W-1:0];
    end

    case (st_next.ref_code)
      aocs_pkg::REF_NEG10:  st_next.ref_en = 1'b1;
      aocs_pkg::REF_ZERO:   st_next.ref_en = 1'b1;
      aocs_pkg::REF_POS10:  st_next.ref_en = 1'b1;
      aocs_pkg::REF_UNUSED: st_next.ref_en = 1'b0;
      default:              st_next.ref_en = 1'b0;
    endcase

    // read-back: only the trim offset answers, all else reads zero
    if (io_rd) begin
      st_next.rvalid = 1'b1;
      if (io_addr == aocs_pkg::OFS_TRIM) begin
        st_next.rdata = {aocs_pkg::UPPER_ZERO, cal_result};
      end else begin
        st_next.rdata = aocs_pkg::RDATA_RESET;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= ST_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign io_rdata                  = st_reg.rdata;
  assign io_rvalid                 = st_reg.rvalid;
  assign cal_trim_value            = st_reg.trim;
  assign cal_trim_load             = st_reg.trim_stb;
  assign cal_param_save            = st_reg.save_stb;
  assign cal_ctrl_reset            = st_reg.cal_rst_stb;
  assign chan_update               = st_reg.update;
  assign chan_pending              = st_reg.pend;
  assign all_outputs_reset         = st_reg.rst_all_stb;
  assign output_type_apply         = st_reg.type_chg_stb;
  assign reference_select_high_bit = st_reg.ref_code[1];
  assign reference_select_low_bit  = st_reg.ref_code[0];
  assign reference_enable          = st_reg.ref_en;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  sequence host_write_s(logic [aocs_pkg::ADDR_W-1:0] ofs);
    io_wr && !$past(io_wr) && io_addr == ofs;
  endsequence

  sequence strobe_due_s(logic pulse);
    ##2 pulse ##1 !pulse;
  endsequence

  trim_capture_a: assert property (
    host_write_s(aocs_pkg::OFS_TRIM) |->
      ##2 (cal_trim_load && cal_trim_value == $past(io_wdata[7:0], 2))
  ) else $error("trim value not captured from low byte");

  trim_readback_a: assert property (
    io_rd && io_addr == aocs_pkg::OFS_TRIM |=>
      io_rvalid && io_rdata == {8'h00, $past(cal_result)}
  ) else $error("trim read-back wrong");

  rdata_upper_a: assert property (
    io_rvalid |-> io_rdata[15:8] == 8'h00
  ) else $error("upper read byte not zero");

  save_armed_a: assert property (
    cal_param_save |-> $past(st_reg.trim_armed) && !st_reg.trim_armed
  ) else $error("save without a prior trim write");

  save_issue_a: assert property (
    wstb.save && st_reg.trim_armed && !wstb.cal_rst |=> cal_param_save
  ) else $error("save strobe lost");

  sync_update_a: assert property (
    wstb.sync |=> chan_update == $past(chan_pending) && chan_pending == '0
  ) else $error("sync strobe did not release pending channels");

  held_write_a: assert property (
    wstb.chan && sync_mode_en && !wstb.rst_all |=>
      chan_update == '0 && chan_pending[$past(wstb.chan_idx)]
  ) else $error("sync-mode write not held");

  direct_write_a: assert property (
    wstb.chan && !sync_mode_en |=> chan_update == (8'h01 << $past(wstb.chan_idx))
  ) else $error("direct write not applied at once");

  reset_all_a: assert property (
    host_write_s(aocs_pkg::OFS_RST_ALL) |-> strobe_due_s(all_outputs_reset)
  ) else $error("reset-all pulse missing or stretched");

  cal_reset_a: assert property (
    host_write_s(aocs_pkg::OFS_CAL_RST) |->
      ##2 (cal_ctrl_reset && !st_reg.trim_armed)
  ) else $error("calibration controller reset missing");

  type_apply_a: assert property (
    host_write_s(aocs_pkg::OFS_TYPE_CHG) |-> strobe_due_s(output_type_apply)
  ) else $error("output type pulse missing or stretched");

  ref_code_a: assert property (
    wstb.ref_sel |=> {reference_select_high_bit, reference_select_low_bit}
                     == $past(wstb.data[1:0])
  ) else $error("reference code not taken from bits 1..0");

  ref_unused_a: assert property (
    {reference_select_high_bit, reference_select_low_bit} == aocs_pkg::REF_UNUSED
      |-> !reference_enable
  ) else $error("unused reference code left a reference applied");

  // ----------------------------------------------------------------
  // quiet checks: nothing moves unless the host asked for it; a valid reference code keeps the reference on
  // ----------------------------------------------------------------
  save_dropped_a: assert property (
    wstb.save && !st_reg.trim_armed |=> !cal_param_save
  ) else $error("save issued with no trim since last save");

  pend_stable_a: assert property (
    !(wstb.chan || wstb.sync || wstb.rst_all) |=> $stable(chan_pending)
  ) else $error("pending channels changed with no write");

  reset_pend_a: assert property (
    wstb.rst_all |=> all_outputs_reset && chan_pending == '0
  ) else $error("reset-all left channels pending");

  trim_hold_a: assert property (
    !wstb.trim |=> !cal_trim_load && $stable(cal_trim_value)
  ) else $error("trim value moved without a trim write");

  ref_hold_a: assert property (
    !wstb.ref_sel |=>
      $stable({reference_select_high_bit, reference_select_low_bit})
  ) else $error("reference code moved without a select write");

  ref_enable_a: assert property (
    {reference_select_high_bit, reference_select_low_bit} != aocs_pkg::REF_UNUSED
      |-> reference_enable
  ) else $error("valid reference code left the reference off");

  rvalid_once_a: assert property (
    !io_rd |=> !io_rvalid
  ) else $error("read answer without a read");

  rdata_hold_a: assert property (
    !io_rd |=> $stable(io_rdata)
  ) else $error("read data moved without a read");

  update_source_a: assert property (
    chan_update != '0 |-> $past(wstb.sync) || $past(wstb.chan && !sync_mode_en)
  ) else $error("channel update with no sync strobe or direct write");

  strobe_source_a: assert property (
    cal_ctrl_reset || all_outputs_reset || output_type_apply |->
      $past(wstb.cal_rst || wstb.rst_all || wstb.type_chg)
  ) else $error("strobe pulse with no matching write");

endmodule : aocs_regs

`default_nettype wire

// ### tb/aocs_host_model.sv
// Purpose: host side of the word-wide I/O window, issues reads and writes
// Assumes: requests launched at the falling edge of clk_sys
// Notes:   address and data show an inverted pattern once released
`default_nettype none

module aocs_host_model (
  input  wire logic                        clk_sys,
  output var  logic                        io_wr,
  output var  logic                        io_rd,
  output var  logic [aocs_pkg::ADDR_W-1:0] io_addr,
  output var  logic [aocs_pkg::DATA_W-1:0] io_wdata
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    io_wr    = 1'b0;
    io_rd    = 1'b0;
    io_addr  = 6'h3f;
    io_wdata = 16'hffff;
  end

  // whole words only; held io_wr counts as one write
  task automatic wr(input logic [5:0] a, input logic [15:0] d, input int hold);
    @(negedge clk_sys);
    io_addr  = a;
    io_wdata = d;
    io_wr    = 1'b1;
    repeat (hold) @(negedge clk_sys);
    io_wr    = 1'b0;
    io_addr  = ~a;
    io_wdata = ~d;
  endtask : wr

  task automatic rd(input logic [5:0] a);
    @(negedge clk_sys);
    io_addr = a;
    io_rd   = 1'b1;
    @(negedge clk_sys);
    io_rd   = 1'b0;
    io_addr = ~a;
  endtask : rd
endmodule : aocs_host_model

`default_nettype wire

// ### tb/tb.sv
// Purpose: self-checking bench for the calibration strobe register block
// Assumes: one write at a time, outputs settle two edges after the write
// Notes:   inputs change and outputs are sampled at the falling edge
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk_sys = 1'b0;
  logic        rst_b = 1'b0;
  logic        io_wr, io_rd, io_rvalid, sync_mode_en;
  logic [5:0]  io_addr;
  logic [15:0] io_wdata, io_rdata;
  logic [7:0]  cal_result, cal_trim_value, chan_update, chan_pending;
  logic        cal_trim_load, cal_param_save, cal_ctrl_reset;
  logic        all_outputs_reset, output_type_apply, reference_enable;
  logic        reference_select_high_bit, reference_select_low_bit;
  logic [4:0]  pulses;
  logic [31:0] seed = 32'h088c_8b89;
  logic [7:0]  exp_pend = 8'h00;
  logic [7:0]  exp_trim = 8'h00;
  logic [1:0]  exp_ref = 2'h1;
  logic        armed = 1'b0;
  int          num_errors = 0;
  int          num_checks = 0;
  int          n_type = 0;
  logic [5:0]  ofs [10] = '{6'h1e, 6'h18, 6'h20, 6'h22, 6'h24, 6'h26, 6'h28, 6'h2a,
                            6'h04, 6'h0f};

  assign pulses = {cal_trim_load, cal_param_save, cal_ctrl_reset, all_outputs_reset,
                   output_type_apply};

  always #5 clk_sys = ~clk_sys;

  always @(negedge clk_sys) begin
    if (output_type_apply === 1'b1) n_type++;
  end

  aocs_host_model host (.clk_sys(clk_sys), .io_wr(io_wr), .io_rd(io_rd),
                        .io_addr(io_addr), .io_wdata(io_wdata));

  aocs_regs dut (
    .clk_sys(clk_sys), .rst_b(rst_b), .io_wr(io_wr), .io_rd(io_rd),
    .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .io_rvalid(io_rvalid), .sync_mode_en(sync_mode_en), .cal_result(cal_result),
    .cal_trim_value(cal_trim_value), .cal_trim_load(cal_trim_load),
    .cal_param_save(cal_param_save), .cal_ctrl_reset(cal_ctrl_reset),
    .chan_update(chan_update), .chan_pending(chan_pending),
    .all_outputs_reset(all_outputs_reset), .output_type_apply(output_type_apply),
    .reference_select_high_bit(reference_select_high_bit),
    .reference_select_low_bit(reference_select_low_bit),
    .reference_enable(reference_enable));

  function automatic logic [31:0] nxt();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : nxt

  // save is dropped unless a trim came since the last save or controller reset
  function automatic logic [4:0] exp_pulse(input logic [5:0] a, input logic arm);
    case (a)
      6'h1e:   return 5'h10;
      6'h18:   return arm ? 5'h08 : 5'h00;
      6'h24:   return 5'h04;
      6'h22:   return 5'h02;
      6'h26:   return 5'h01;
      default: return 5'h00;
    endcase
  endfunction : exp_pulse

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic wchk(input logic [5:0] a, input logic [15:0] d);
    logic [7:0] upd;
    logic [4:0] pls;
    upd = 8'h00;
    pls = exp_pulse(a, armed);
    if (a <= 6'h0f && sync_mode_en) exp_pend[a[3:1]] = 1'b1;
    if (a <= 6'h0f && !sync_mode_en) upd[a[3:1]] = 1'b1;
    if (a == 6'h20) upd = exp_pend;
    if (a == 6'h20 || a == 6'h22) exp_pend = 8'h00;
    if (a == 6'h1e) exp_trim = d[7:0];
    if (a == 6'h18 || a == 6'h24) armed = 1'b0;
    if (a == 6'h1e) armed = 1'b1;
    if (a == 6'h28) exp_ref = d[1:0];
    host.wr(a, d, 1);
    @(negedge clk_sys);
    chk("pulses", pulses, pls);
    chk("updates", chan_update, upd);
    chk("trim", cal_trim_value, exp_trim);
    chk("pending", chan_pending, exp_pend);
    chk("ref", {reference_enable, reference_select_high_bit, reference_select_low_bit},
        {exp_ref != 2'h2, exp_ref});
    @(negedge clk_sys);
    chk("pulse end", {pulses, chan_update}, 13'h0000);
  endtask : wchk

  task automatic rchk(input logic [5:0] a);
    logic [31:0] r;
    r = nxt();
    cal_result = r[7:0];
    host.rd(a);
    chk("rvalid", io_rvalid, 1'b1);
    chk("rdata", io_rdata, (a == 6'h1e) ? {8'h00, r[7:0]} : 16'h0000);
    @(negedge clk_sys);
    chk("rvalid end", io_rvalid, 1'b0);
  endtask : rchk

  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done

  initial begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    $display("Error watchdog expected done seen timeout");
    test_done();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    logic [31:0] r;
    int          n0;
    sync_mode_en = 1'b0;
    cal_result   = 8'h00;
    repeat (12) @(negedge clk_sys);
    rst_b = 1'b1;
    chk("reset ref", {reference_enable, reference_select_high_bit,
        reference_select_low_bit}, 3'h5);
    chk("reset trim", cal_trim_value, 8'h00);
    $display("test reset done");
    wchk(6'h14 + 6'h0a, 16'hab5a);
    wchk(6'h18, 16'h0000);
    wchk(6'h18, 16'hffff);
    wchk(6'h1e, 16'hff01);
    wchk(6'h24, 16'h1234);
    wchk(6'h18, 16'h0000);
    $display("test save done");
    sync_mode_en = 1'b1;
    wchk(6'h00, 16'h8000);
    wchk(6'h0e, 16'hffff);
    wchk(6'h07, 16'h1111);
    wchk(6'h20, 16'h5a5a);
    wchk(6'h04, 16'h0001);
    wchk(6'h22, 16'h0000);
    sync_mode_en = 1'b0;
    wchk(6'h0a, 16'h7777);
    $display("test sync done");
    for (int k = 0; k < 4; k++) begin
      r = nxt();
      wchk(6'h28, {r[15:2], k[1:0]});
    end
    wchk(6'h26, 16'h0000);
    n0 = n_type;
    host.wr(6'h26, 16'h0f0f, 5);
    repeat (4) @(negedge clk_sys);
    chk("held write", n_type - n0, 16'h0001);
    $display("test strobes done");
    for (int i = 0; i < 40; i++) begin
      r = nxt();
      sync_mode_en = r[20];
      wchk(ofs[r[19:16] % 10], r[15:0]);
    end
    $display("test random done");
    rchk(6'h1e);
    rchk(6'h1e);
    rchk(6'h20);
    rchk(6'h2a);
    $display("test read done");
    test_done();
  end
endmodule : tb

`default_nettype wire
